/* File: logic/zsb_pkg.sv */
// zsb_pkg: shared constants of the zone status input bank
// assumes one 200 MHz clock and a read port served by zsb_zone_status_bank
`default_nettype none
package zsb_pkg;
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned MS_PER_SEC   = 1000;
    localparam int unsigned KHZ_PER_MHZ  = 1000;
    localparam int unsigned STALL_SEC    = 20;
    localparam int unsigned MS_CYCLES_DEF = CLK_MHZ * KHZ_PER_MHZ;
    localparam int unsigned STALL_MS_DEF  = STALL_SEC * MS_PER_SEC;
    // module register addresses
    localparam logic [15:0] REG_STAT_LEFT = 16'h0058;
    localparam logic [15:0] REG_UP_ARR    = 16'h006A;
    localparam logic [15:0] REG_UP_DEP    = 16'h006B;
    localparam logic [15:0] REG_UP_STATE  = 16'h0074;
    localparam logic [15:0] REG_DN_ARR    = 16'h00BA;
    localparam logic [15:0] REG_DN_DEP    = 16'h00BB;
    localparam logic [15:0] REG_DN_STATE  = 16'h00C4;
    // assembly: first word 1500, word order below
    localparam logic [15:0] ASM_BASE = 16'h05DC;
    localparam logic [2:0]  AW_UP_STATE = 3'h0;
    localparam logic [2:0]  AW_DN_STATE = 3'h1;
    localparam logic [2:0]  AW_UP_ARR   = 3'h2;
    localparam logic [2:0]  AW_UP_DEP   = 3'h3;
    localparam logic [2:0]  AW_DN_ARR   = 3'h4;
    localparam logic [2:0]  AW_DN_DEP   = 3'h5;
    localparam logic [2:0]  AW_STATUS   = 3'h6;
    localparam logic [2:0]  AW_NONE     = 3'h7;
    localparam logic [5:0]  MAX_SPAN    = 6'h2D;
    // service codes
    localparam logic [7:0] SVC_READ   = 8'h03;
    localparam logic [7:0] SVC_WRITE1 = 8'h06;
    localparam logic [7:0] SVC_WRITEN = 8'h10;
    localparam logic [7:0] SVC_RDWR   = 8'h17;
    // zone state codes
    localparam logic [7:0] ZS_IDLE   = 8'h01;
    localparam logic [7:0] ZS_ACCEPT = 8'h02;
    localparam logic [7:0] ZS_DISCH  = 8'h04;
    localparam logic [7:0] ZS_HELD   = 8'h05;
    localparam logic [7:0] ZS_BUSY   = 8'h06;
    // status word fields
    localparam logic [15:0] STATUS_RST = 16'h0001;
    localparam int SB_RESET = 0;
    localparam int SB_RSVD  = 1;
    localparam int SB_OVERV = 2;
    localparam int SB_LMERR = 3;
    localparam int SB_NET   = 4;
    localparam int SB_JAM   = 5;
    localparam int SB_LSENS = 6;
    localparam int SB_UNDERV = 7;
    localparam int SB_HOT   = 8;
    localparam int SB_MAXTQ = 9;
    localparam int SB_SHORT = 10;
    localparam int SB_OPEN  = 11;
    localparam int SB_OVLD  = 12;
    localparam int SB_STALL = 13;
    localparam int SB_HALL  = 14;
    localparam int SB_UNUSED = 15;
    // stall threshold as a percentage
    localparam logic [23:0] STALL_PCT = 24'h00_000A;
    localparam logic [23:0] PCT_FULL  = 24'h00_0064;
endpackage : zsb_pkg
`default_nettype wire

/* File: logic/zsb_zone_if.sv */
// zsb_zone_if: one zone's sensor level and carton counters
// assumes both ends run on mclk
`timescale 1ns/1ps
`default_nettype none
interface zsb_zone_if;
    logic        blocked;
    logic [15:0] arrCnt;
    logic [15:0] depCnt;
    modport cnt  (input blocked, output arrCnt, output depCnt);
    modport bank (output blocked, input arrCnt, input depCnt);
endinterface : zsb_zone_if
`default_nettype wire

/* File: logic/zsb_carton_counter.sv */
// zsb_carton_counter: arrival and departure counts of one zone
// assumes zone.blocked is already synchronised to mclk
`timescale 1ns/1ps
`default_nettype none
module zsb_carton_counter
    import zsb_pkg::*;
(
    input  wire logic mclk,
    input  wire logic nrst,
    zsb_zone_if.cnt   zone
);
    logic blkPrev_ff;
    logic arrive;
    logic depart;

    assign arrive = zone.blocked & ~blkPrev_ff;
    assign depart = ~zone.blocked & blkPrev_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            blkPrev_ff <= 1'b0;
        end else begin
            blkPrev_ff <= zone.blocked;
        end
    end

    // plain 16-bit adders wrap by themselves
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            zone.arrCnt <= 16'h0000;
            zone.depCnt <= 16'h0000;
        end else begin
            if (arrive) zone.arrCnt <= zone.arrCnt + 16'h0001;
            if (depart) zone.depCnt <= zone.depCnt + 16'h0001;
        end
    end

    a_arrival_step: assert property (@(posedge mclk) disable iff (!nrst)
        arrive |=> zone.arrCnt == 16'($past(zone.arrCnt) + 16'h0001))
        else $error("arrival count did not step");
    a_depart_step: assert property (@(posedge mclk) disable iff (!nrst)
        (depart ##1 !depart) |-> zone.depCnt == 16'($past(zone.depCnt) + 16'h0001))
        else $error("departure count did not step");
    a_count_wrap: assert property (@(posedge mclk) disable iff (!nrst)
        (arrive && zone.arrCnt == 16'hFFFF) |=> zone.arrCnt == 16'h0000)
        else $error("arrival count did not wrap");
endmodule : zsb_carton_counter
`default_nettype wire

/* File: logic/zsb_stall_timer.sv */
// zsb_stall_timer: raises overload after a long continuous stall
// assumes msTick is a one-cycle pulse every millisecond
`timescale 1ns/1ps
`default_nettype none
module zsb_stall_timer #(
    parameter int unsigned STALL_MS = 20000
) (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic msTick,
    input  wire logic stalled,
    output var  logic overload_ff
);
    logic [31:0] cnt_ff;

    // saturates so a very long stall cannot wrap back to healthy
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff      <= 32'h0000_0000;
            overload_ff <= 1'b0;
        end else if (!stalled) begin
            cnt_ff      <= 32'h0000_0000;
            overload_ff <= 1'b0;
        end else begin
            if (msTick && cnt_ff < STALL_MS) cnt_ff <= cnt_ff + 32'h0000_0001;
            overload_ff <= (cnt_ff >= STALL_MS);
        end
    end

    a_overload_clear: assert property (@(posedge mclk) disable iff (!nrst)
        !stalled |=> !overload_ff)
        else $error("overload stayed after stall ended");
    a_overload_time: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(overload_ff) |-> $past(cnt_ff) == STALL_MS && $past(stalled))
        else $error("overload raised at the wrong stall time");
endmodule : zsb_stall_timer
`default_nettype wire

/* File: logic/zsb_zone_status_bank.sv */
// zsb_zone_status_bank: read-only zone status bank and its request port
// assumes pins are asynchronous; speeds and requests come from mclk logic
`timescale 1ns/1ps
`default_nettype none
module zsb_zone_status_bank
    import zsb_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
    parameter int unsigned STALL_MS  = STALL_MS_DEF
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        upSensorPin,
    input  wire logic        dnSensorPin,
    input  wire logic        upRunPin,
    input  wire logic        dnRunPin,
    input  wire logic        netStopBusyPin,
    input  wire logic        reversePin,
    input  wire logic        plcConnPin,
    input  wire logic        overVoltPin,
    input  wire logic        underVoltPin,
    input  wire logic        netBadPin,
    input  wire logic        upJamPin,
    input  wire logic        leftSensErrPin,
    input  wire logic        leftHotPin,
    input  wire logic        leftMaxTqPin,
    input  wire logic        leftShortPin,
    input  wire logic        leftOpenPin,
    input  wire logic        leftHallErrPin,
    input  wire logic        leftUnusedPin,
    input  wire logic [15:0] leftSpeed,
    input  wire logic [15:0] leftSetSpeed,
    input  wire logic        reqValid,
    input  wire logic [7:0]  reqSvc,
    input  wire logic        reqAsm,
    input  wire logic [15:0] reqAddr,
    input  wire logic [5:0]  reqCount,
    output var  logic        reqReady_ff,
    output var  logic        rspValid_ff,
    output var  logic [15:0] rspData_ff,
    output var  logic        rspLast_ff,
    output var  logic        rspErr_ff,
    input  wire logic        byteRdEn,
    input  wire logic [5:0]  byteIdx,
    output var  logic        byteValid_ff,
    output var  logic [7:0]  byteData_ff
);
    typedef enum logic {ST_IDLE, ST_STREAM} zsb_state_t;

    logic [17:0]       pinMeta_ff;
    logic [17:0]       pinSync_ff;
    logic              upBlk, dnBlk, upRun, dnRun, stopBusy, reverse, plcConn;
    logic              overV, underV, netBad, upJam, lSens, lHot, lMaxTq;
    logic              lShort, lOpen, lHall, lUnused;
    logic [15:0]       upWord_ff, dnWord_ff, statusWord_ff, nxt_statusWord;
    logic [6:0][15:0]  img;
    logic [31:0]       msCnt_ff;
    logic              msTick_ff;
    logic              stalledNow, overload;
    zsb_state_t        state_ff;
    logic [15:0]       curAddr_ff;
    logic [5:0]        left_ff;
    logic              asmMode_ff;
    logic              accept, isRead, isWrite, reqFault;
    logic [15:0]       byteWord;

    zsb_zone_if upZone ();
    zsb_zone_if dnZone ();

    function automatic logic [15:0] zoneWord(input logic blk, input logic run,
                                             input logic busy, input logic rev);
        logic [7:0] code;
        code = ZS_IDLE;
        if (busy)            code = ZS_BUSY;
        else if (blk && run) code = ZS_DISCH;
        else if (blk)        code = ZS_HELD;
        else if (run)        code = ZS_ACCEPT;
        // only the running direction's byte carries a code
        return rev ? {code, 8'h00} : {8'h00, code};
    endfunction : zoneWord

    function automatic logic [2:0] modIdx(input logic [15:0] addr);
        case (addr)
            REG_UP_STATE:  return AW_UP_STATE;
            REG_DN_STATE:  return AW_DN_STATE;
            REG_UP_ARR:    return AW_UP_ARR;
            REG_UP_DEP:    return AW_UP_DEP;
            REG_DN_ARR:    return AW_DN_ARR;
            REG_DN_DEP:    return AW_DN_DEP;
            REG_STAT_LEFT: return AW_STATUS;
            default:       return AW_NONE;
        endcase
    endfunction : modIdx

    // words past the status word belong to other banks and read zero
    function automatic logic [15:0] pickWord(input logic [6:0][15:0] im,
                                             input logic [15:0] idx);
        return (idx < 16'(AW_NONE)) ? im[idx[2:0]] : 16'h0000;
    endfunction : pickWord

    function automatic logic [15:0] wordAt(input logic [6:0][15:0] im,
                                           input logic asmMode, input logic [15:0] addr);
        logic [2:0] mi;
        mi = modIdx(addr);
        if (asmMode) return pickWord(im, 16'(addr - ASM_BASE));
        return pickWord(im, {13'h0000, mi});
    endfunction : wordAt

    // two-stage synchroniser on every pin
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pinMeta_ff <= 18'h0_0000;
            pinSync_ff <= 18'h0_0000;
        end else begin
            pinMeta_ff <= {upSensorPin, dnSensorPin, upRunPin, dnRunPin, netStopBusyPin,
                           reversePin, plcConnPin, overVoltPin, underVoltPin, netBadPin,
                           upJamPin, leftSensErrPin, leftHotPin, leftMaxTqPin,
                           leftShortPin, leftOpenPin, leftHallErrPin, leftUnusedPin};
            pinSync_ff <= pinMeta_ff;
        end
    end

    assign {upBlk, dnBlk, upRun, dnRun, stopBusy, reverse, plcConn, overV, underV,
            netBad, upJam, lSens, lHot, lMaxTq, lShort, lOpen, lHall, lUnused} = pinSync_ff;

    assign upZone.blocked = upBlk;
    assign dnZone.blocked = dnBlk;

    zsb_carton_counter u_upCount (.mclk(mclk), .nrst(nrst), .zone(upZone));
    zsb_carton_counter u_dnCount (.mclk(mclk), .nrst(nrst), .zone(dnZone));

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            upWord_ff <= 16'h0000;
            dnWord_ff <= 16'h0000;
        end else begin
            upWord_ff <= zoneWord(upBlk, upRun, stopBusy, reverse);
            dnWord_ff <= zoneWord(dnBlk, dnRun, stopBusy, reverse);
        end
    end

    // millisecond enable for the stall timer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            msCnt_ff  <= 32'h0000_0000;
            msTick_ff <= 1'b0;
        end else begin
            msTick_ff <= (msCnt_ff == MS_CYCLES - 1);
            msCnt_ff  <= (msCnt_ff == MS_CYCLES - 1) ? 32'h0000_0000 : msCnt_ff + 32'h0000_0001;
        end
    end

    // products kept at 24 bits so full-scale speeds cannot overflow
    assign stalledNow = (leftSetSpeed != 16'h0000) &&
        ({8'h00, leftSpeed} * PCT_FULL < {8'h00, leftSetSpeed} * STALL_PCT);

    zsb_stall_timer #(.STALL_MS(STALL_MS)) u_stall (
        .mclk        (mclk),
        .nrst        (nrst),
        .msTick      (msTick_ff),
        .stalled     (stalledNow),
        .overload_ff (overload)
    );

    always_comb begin
        nxt_statusWord            = 16'h0000;
        nxt_statusWord[SB_RESET]  = statusWord_ff[SB_RESET] & ~plcConn;
        nxt_statusWord[SB_OVERV]  = overV;
        nxt_statusWord[SB_UNDERV] = underV;
        nxt_statusWord[SB_NET]    = netBad;
        nxt_statusWord[SB_JAM]    = upJam;
        nxt_statusWord[SB_LSENS]  = lSens;
        nxt_statusWord[SB_HOT]    = lHot;
        nxt_statusWord[SB_MAXTQ]  = lMaxTq;
        nxt_statusWord[SB_SHORT]  = lShort;
        nxt_statusWord[SB_OPEN]   = lOpen;
        nxt_statusWord[SB_OVLD]   = overload;
        nxt_statusWord[SB_STALL]  = stalledNow;
        nxt_statusWord[SB_HALL]   = lHall;
        nxt_statusWord[SB_UNUSED] = lUnused;
        // "not used" is a setting, not a fault, so it stays out of the summary
        nxt_statusWord[SB_LMERR]  = |nxt_statusWord[SB_HALL:SB_HOT];
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            statusWord_ff <= STATUS_RST;
        end else begin
            statusWord_ff <= nxt_statusWord;
        end
    end

    assign img = {statusWord_ff, dnZone.depCnt, dnZone.arrCnt, upZone.depCnt,
                  upZone.arrCnt, dnWord_ff, upWord_ff};

    assign accept  = reqValid && reqReady_ff;
    assign isRead  = (reqSvc == SVC_READ) || (reqSvc == SVC_RDWR);
    assign isWrite = (reqSvc == SVC_WRITE1) || (reqSvc == SVC_WRITEN);
    assign reqFault = !(isRead || isWrite) ||
        (reqSvc != SVC_WRITE1 && (reqCount == 6'h00 || reqCount > MAX_SPAN)) ||
        (reqAsm && reqAddr != ASM_BASE);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff    <= ST_IDLE;
            reqReady_ff <= 1'b1;
            rspValid_ff <= 1'b0;
            rspData_ff  <= 16'h0000;
            rspLast_ff  <= 1'b0;
            rspErr_ff   <= 1'b0;
            curAddr_ff  <= 16'h0000;
            left_ff     <= 6'h00;
            asmMode_ff  <= 1'b0;
        end else begin
            rspValid_ff <= 1'b0;
            rspLast_ff  <= 1'b0;
            rspErr_ff   <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    reqReady_ff <= 1'b1;
                    if (accept) begin
                        reqReady_ff <= 1'b0;
                        if (reqFault || isWrite) begin
                            // writes are acknowledged; this bank holds nothing writable
                            rspValid_ff <= 1'b1;
                            rspLast_ff  <= 1'b1;
                            rspErr_ff   <= reqFault;
                            rspData_ff  <= 16'h0000;
                        end else begin
                            state_ff   <= ST_STREAM;
                            curAddr_ff <= reqAddr;
                            left_ff    <= reqCount;
                            asmMode_ff <= reqAsm;
                        end
                    end
                end
                ST_STREAM: begin
                    rspValid_ff <= 1'b1;
                    rspData_ff  <= wordAt(img, asmMode_ff, curAddr_ff);
                    rspLast_ff  <= (left_ff == 6'h01);
                    curAddr_ff  <= curAddr_ff + 16'h0001;
                    left_ff     <= left_ff - 6'h01;
                    if (left_ff == 6'h01) begin
                        state_ff    <= ST_IDLE;
                        reqReady_ff <= 1'b1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // byte view of the assembly
    assign byteWord = pickWord(img, {11'h000, byteIdx[5:1]});

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            byteValid_ff <= 1'b0;
            byteData_ff  <= 8'h00;
        end else begin
            byteValid_ff <= byteRdEn;
            if (byteRdEn) begin
                byteData_ff <= byteIdx[0] ? byteWord[7:0] : byteWord[15:8];
            end
        end
    end

    a_zone_idle: assert property (@(posedge mclk) disable iff (!nrst)
        (!upBlk && !upRun && !stopBusy && !reverse) |=> upWord_ff == {8'h00, ZS_IDLE})
        else $error("idle zone code wrong");
    a_zone_held: assert property (@(posedge mclk) disable iff (!nrst)
        (dnBlk && !dnRun && !stopBusy && !reverse) |=> dnWord_ff == {8'h00, ZS_HELD})
        else $error("held zone code wrong");
    a_zone_busy: assert property (@(posedge mclk) disable iff (!nrst)
        (stopBusy && reverse) |=> upWord_ff == {ZS_BUSY, 8'h00} && dnWord_ff == {ZS_BUSY, 8'h00})
        else $error("busy code or reverse byte placement wrong");
    a_byte_order: assert property (@(posedge mclk) disable iff (!nrst)
        (byteRdEn && byteIdx == 6'h0C) |=> byteData_ff == $past(statusWord_ff[15:8]))
        else $error("status high byte not at even offset");
    a_reserved_bit: assert property (@(posedge mclk) disable iff (!nrst)
        $past(statusWord_ff[SB_RSVD]) == 1'b0 && statusWord_ff[SB_RSVD] == 1'b0)
        else $error("reserved status bit set");
    a_reset_flag: assert property (@(posedge mclk) disable iff (!nrst)
        (plcConn || !statusWord_ff[SB_RESET]) |=> !statusWord_ff[SB_RESET])
        else $error("reset flag not cleared or came back");
    a_motor_summary: assert property (@(posedge mclk) disable iff (!nrst)
        statusWord_ff[SB_LMERR] == |statusWord_ff[SB_HALL:SB_HOT])
        else $error("motor error summary mismatch");
    a_fault_follow: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(overV) |=> !statusWord_ff[SB_OVERV])
        else $error("over-voltage bit latched");
    a_stall_flag: assert property (@(posedge mclk) disable iff (!nrst)
        (leftSetSpeed == 16'h0064 && leftSpeed == 16'h0009) |=> statusWord_ff[SB_STALL])
        else $error("stall below tenth of speed not flagged");
    a_start_error: assert property (@(posedge mclk) disable iff (!nrst)
        (accept && reqAsm && reqAddr != ASM_BASE) |=> rspValid_ff && rspErr_ff && rspLast_ff)
        else $error("bad assembly start not refused");
    a_span_limit: assert property (@(posedge mclk) disable iff (!nrst)
        (accept && !reqFault && isRead && reqCount == 6'h02)
        |=> !rspValid_ff ##1 rspValid_ff && !rspLast_ff ##1 rspValid_ff && rspLast_ff)
        else $error("read stream length wrong");
endmodule : zsb_zone_status_bank
`default_nettype wire

/* File: dv/zsb_ctrl_model.sv */
// zsb_ctrl_model: network controller at the request port of the bank
// assumes one mclk shared with the bank
`timescale 1ns/1ps
`default_nettype none
module zsb_ctrl_model (
    input  wire logic        mclk,
    input  wire logic        reqReady_ff,
    input  wire logic        rspValid_ff,
    input  wire logic [15:0] rspData_ff,
    input  wire logic        rspLast_ff,
    input  wire logic        rspErr_ff,
    output var  logic        reqValid,
    output var  logic [7:0]  reqSvc,
    output var  logic        reqAsm,
    output var  logic [15:0] reqAddr,
    output var  logic [5:0]  reqCount
);
    logic [15:0] w [0:63];
    int          nw;
    logic        err;
    initial {reqValid, reqSvc, reqAsm, reqAddr, reqCount} = '0;
    // callers pick service, address space, start word and span
    task automatic xfer(input logic [7:0] s, input logic m, input logic [15:0] a,
                        input logic [5:0] n);
        @(posedge mclk);
        {reqValid, reqSvc, reqAsm, reqAddr, reqCount} <= {1'b1, s, m, a, n};
        do @(posedge mclk); while (reqReady_ff !== 1'b1);
        reqValid <= 1'b0;
        reqAddr  <= ~a; // released address no longer shows the old value
        nw = 0;
        err = 1'b0;
        repeat (60) begin
            @(posedge mclk);
            if (rspValid_ff === 1'b1) begin
                w[nw] = rspData_ff;
                nw++;
                err |= rspErr_ff;
                if (rspLast_ff === 1'b1) break;
            end
        end
    endtask : xfer
endmodule : zsb_ctrl_model
`default_nettype wire

/* File: dv/test_zone_status_input_bank.sv */
// test_zone_status_input_bank: self-checking bench of the zone status bank
// assumes zsb_ctrl_model plays the controller
`timescale 1ns/1ps
`default_nettype none
module test_zone_status_input_bank;
    import zsb_pkg::*;
    logic mclk, nrst, busy, rev, conn, byteRdEn, byteValid_ff, reqValid, reqAsm;
    logic reqReady_ff, rspValid_ff, rspLast_ff, rspErr_ff;
    logic [1:0] sens, run;
    logic [5:0] byteIdx, reqCount;
    logic [7:0] reqSvc, byteData_ff, bh, bl;
    logic [15:0] flt, leftSpeed, leftSetSpeed, reqAddr, rspData_ff;
    logic [15:0] w [0:63];
    logic [63:0] b;
    logic [7:0] svcs [0:3];
    int errors, n_tests, seed, i;
    zsb_zone_status_bank #(.MS_CYCLES(4), .STALL_MS(8)) zsb_zone_status_bank_inst (.mclk,
      .nrst, .upSensorPin(sens[1]), .dnSensorPin(sens[0]), .upRunPin(run[1]),
      .dnRunPin(run[0]), .netStopBusyPin(busy), .reversePin(rev), .plcConnPin(conn),
      .overVoltPin(flt[2]), .netBadPin(flt[4]), .upJamPin(flt[5]), .leftSensErrPin(flt[6]),
      .underVoltPin(flt[7]), .leftHotPin(flt[8]), .leftMaxTqPin(flt[9]),
      .leftShortPin(flt[10]), .leftOpenPin(flt[11]), .leftHallErrPin(flt[14]),
      .leftUnusedPin(flt[15]), .leftSpeed, .leftSetSpeed, .reqValid, .reqSvc, .reqAsm,
      .reqAddr, .reqCount, .reqReady_ff, .rspValid_ff, .rspData_ff, .rspLast_ff,
      .rspErr_ff, .byteRdEn, .byteIdx, .byteValid_ff, .byteData_ff);
    zsb_ctrl_model zsb_ctrl_model_inst (.mclk, .reqReady_ff, .rspValid_ff, .rspData_ff,
      .rspLast_ff, .rspErr_ff, .reqValid, .reqSvc, .reqAsm, .reqAddr, .reqCount);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [15:0] zw(logic s, logic r, logic y, logic v);
        logic [7:0] z;
        z = y ? ZS_BUSY : s ? (r ? ZS_DISCH : ZS_HELD) : (r ? ZS_ACCEPT : ZS_IDLE);
        zw = v ? {z, 8'h00} : {8'h00, z};
    endfunction : zw
    function automatic logic [15:0] exps(logic [15:0] f, logic st, logic ov);
        exps = (f & 16'hCFF4) | {2'b00, st, ov, 12'h000};
        exps[3] = |(exps & 16'h7F00);
    endfunction : exps
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(logic [7:0] s, logic [15:0] a, logic [5:0] n);
        repeat (6) @(posedge mclk); // pins reach the words 3 edges later
        zsb_ctrl_model_inst.xfer(s, 1'b1, a, n);
        w = zsb_ctrl_model_inst.w;
    endtask : rd
    task automatic rdb(logic [5:0] x, output logic [7:0] v);
        @(posedge mclk);
        byteIdx <= x;
        byteRdEn <= 1'b1;
        @(posedge mclk);
        byteRdEn <= 1'b0;
        v = 8'hxx;
        repeat (3) begin
            @(negedge mclk);
            if (byteValid_ff === 1'b1) v = byteData_ff;
        end
    endtask : rdb
    task automatic give_verdict();
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        {nrst, sens, run, busy, rev, conn, flt, leftSpeed, leftSetSpeed, byteIdx} = '0;
        byteRdEn = 1'b0;
        svcs = '{SVC_READ, SVC_WRITE1, SVC_WRITEN, SVC_RDWR};
        seed = $urandom(32'h3d42a793);
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        rd(SVC_READ, ASM_BASE, 6'd7);
        chk("status", STATUS_RST, w[6]);
        for (i = 0; i < 6; i++) chk("word", i < 2 ? 16'h0001 : 16'h0000, w[i]);
        for (i = 0; i < 16; i++) begin
            {sens[1], run[1], busy, rev} <= i[3:0];
            {sens[0], run[0]} <= 2'($urandom);
            rd(SVC_READ, ASM_BASE, 6'd2);
            chk("up", zw(sens[1], run[1], busy, rev), w[0]);
            chk("dn", zw(sens[0], run[0], busy, rev), w[1]);
        end
        sens <= 2'b00;
        rd(SVC_READ, ASM_BASE, 6'd6);
        b = {w[2], w[3], w[4], w[5]};
        repeat ($urandom_range(6, 1)) begin
            sens <= 2'b11;
            repeat (5) @(posedge mclk);
            sens <= 2'b00;
            repeat (5) @(posedge mclk);
            b += 64'h0001_0001_0001_0001;
        end
        rd(SVC_READ, ASM_BASE, 6'd6);
        chk("cnt", b[63:48] ^ b[47:32] ^ b[31:16] ^ b[15:0], w[2] ^ w[3] ^ w[4] ^ w[5]);
        chk("upArr", b[63:48], w[2]);
        chk("dnDep", b[15:0], w[5]);
        repeat (6) @(posedge mclk);
        zsb_ctrl_model_inst.xfer(SVC_READ, 1'b0, REG_UP_DEP, 6'd1);
        chk("upDep", b[47:32], zsb_ctrl_model_inst.w[0]);
        conn <= 1'b1;
        repeat (10) begin
            flt <= 16'($urandom);
            rd(SVC_READ, ASM_BASE, 6'd7);
            chk("status", exps(flt, 1'b0, 1'b0), w[6]);
            rdb(6'd12, bh);
            rdb(6'd13, bl);
            chk("bytes", exps(flt, 1'b0, 1'b0), {bh, bl});
            zsb_ctrl_model_inst.xfer(SVC_READ, 1'b0, REG_STAT_LEFT, 6'd1);
            w = zsb_ctrl_model_inst.w;
            chk("modStat", exps(flt, 1'b0, 1'b0), w[0]);
        end
        flt <= 16'h0000;
        {leftSpeed, leftSetSpeed} <= {16'h0009, 16'h0064};
        rd(SVC_READ, ASM_BASE, 6'd7);
        chk("stall", exps(16'h0000, 1'b1, 1'b0), w[6]);
        repeat (40) @(posedge mclk);
        rd(SVC_READ, ASM_BASE, 6'd7);
        chk("ovld", exps(16'h0000, 1'b1, 1'b1), w[6]);
        leftSpeed <= 16'h0064;
        rd(SVC_READ, ASM_BASE, 6'd7);
        chk("clear", 16'h0000, w[6]);
        foreach (svcs[j]) begin
            rd(svcs[j], ASM_BASE, 6'd7);
            chk("svc", j % 3 ? 16'h0001 : 16'h0007, 16'(zsb_ctrl_model_inst.nw));
        end
        rd(SVC_READ, ASM_BASE + 16'h0001, 6'd1);
        chk("offAsm", 16'h0001, 16'(zsb_ctrl_model_inst.err));
        rd(SVC_READ, ASM_BASE, 6'd46);
        chk("span", 16'h0001, 16'(zsb_ctrl_model_inst.err));
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        give_verdict();
    end
endmodule : test_zone_status_input_bank
`default_nettype wire
